// File: common/adc_evt_if.sv
// register access and event lines between converter block and its servicer
`timescale 1ns/1ps
interface adc_evt_if;
   logic        req;
   logic        wr;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        ack;
   logic [3:0]  conv_event;
   modport dev  (input req, wr, addr, wdata, output rdata, ack, conv_event);
   modport host (output req, wr, addr, wdata, input rdata, ack, conv_event);
endinterface : adc_evt_if

// File: common/adc_evt_pkg.sv
// constants shared by the converter event block and its servicing end
package adc_evt_pkg;
   localparam int LINES = 4;
   localparam int PPU   = 2;
   // device register indices on the link
   localparam logic [4:0] A_FLAG     = 5'h00;
   localparam logic [4:0] A_FLAG_CLR = 5'h01;
   localparam logic [4:0] A_LOST     = 5'h02;
   localparam logic [4:0] A_LOST_CLR = 5'h03;
   localparam logic [4:0] A_SEL12    = 5'h04;
   localparam logic [4:0] A_SEL34    = 5'h05;
   localparam logic [4:0] A_RESULT   = 5'h06;
   localparam logic [4:0] A_CTRL     = 5'h07;
   localparam logic [4:0] A_PP_BASE  = 5'h08;
   localparam logic [4:0] A_PP_RES   = 5'h10;
   localparam logic [4:0] A_PP_STAT  = 5'h12;
   // offsets inside a postproc unit's group of four
   localparam logic [1:0] PP_CFG = 2'h0;
   localparam logic [1:0] PP_OFS = 2'h1;
   localparam logic [1:0] PP_HI  = 2'h2;
   localparam logic [1:0] PP_LO  = 2'h3;
   // select pair fields, per half of eight bits
   localparam int SEL_SOC  = 0;
   localparam int SEL_CONT = 2;
   localparam int SEL_HALF = 8;
   // control register fields
   localparam int CTL_DIV   = 0;
   localparam int CTL_RES12 = 4;
   localparam int CTL_LATE  = 5;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] HI_RST   = 16'hffff;
   // divider setting above which, in 12-bit, the late event leads latching by three or more cycles
   localparam logic [3:0] DIV_LEAD = 4'h2;
   localparam logic [3:0] LAT_MIN  = 4'h2;
   // controller apb map
   localparam logic [7:0] H_CTRL   = 8'h00;
   localparam logic [7:0] H_STAT   = 8'h04;
   localparam logic [7:0] H_MASK   = 8'h08;
   localparam logic [7:0] H_CMD    = 8'h0c;
   localparam logic [7:0] H_RDATA  = 8'h10;
   localparam logic [7:0] H_LAST   = 8'h14;
   localparam int HC_SVC  = 0;
   localparam int HC_DUAL = 1;
   localparam int HC_OCLR = 2;
   localparam int HS_SERV = 0;
   localparam int HS_LOST = 1;
   localparam int HS_CMD  = 2;
   localparam int CMD_ADDR = 16;
   localparam int CMD_WR   = 24;
endpackage : adc_evt_pkg

// File: sim/adc_evt_properties.sv
// link checker between the converter block and its servicer
`timescale 1ns/1ps
module adc_evt_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        req,
   input wire logic        wr,
   input wire logic [4:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        ack,
   input wire logic [3:0]  conv_event
);
   logic [3:0] blocked;
   logic [3:0] cont;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // lines whose set flag must hold back further events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blocked <= 4'h0;
      end else begin
         blocked <= (blocked | (conv_event & ~cont))
                    & ~(wdata[3:0] & {4{req && wr && addr == adc_evt_pkg::A_FLAG_CLR}});
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cont <= 4'h0;
      end else if (req && !ack && wr && addr[4:1] == adc_evt_pkg::A_SEL12[4:1]) begin
         cont[2*addr[0] +: 2] <= {wdata[adc_evt_pkg::SEL_HALF+2], wdata[adc_evt_pkg::SEL_CONT]};
      end
   end
   property p_ack_follows; req && !ack |=> ack; endproperty
   property p_ack_pulse; ack |=> !ack; endproperty
   property p_ack_cause; ack |-> $past(req) && !$past(ack); endproperty
   property p_req_hold; req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata);
   endproperty
   property p_rdata_hold; !(req && !wr && !ack) |=> $stable(rdata); endproperty
   property p_unmapped_zero; ack && !wr && addr > 5'h12 |-> rdata == 16'h0000; endproperty
   property p_event_pulse; |conv_event |=> (conv_event & $past(conv_event)) == 4'h0;
   endproperty
   property p_no_refire; (conv_event & blocked & ~cont) == 4'h0; endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("ack missing after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
   a_event_pulse: assert property (p_event_pulse) else $error("event longer than one cycle");
   a_no_refire: assert property (p_no_refire) else $error("event on blocked line");
   c_event: cover property (|conv_event);
   c_clear: cover property (ack && wr && addr == adc_evt_pkg::A_FLAG_CLR);
   c_lost: cover property (ack && !wr && addr == adc_evt_pkg::A_LOST && rdata != 16'h0000);
endmodule : adc_evt_properties

// File: sim/tb.sv
// self-checking bench: apb driven servicer joined to the converter block
`timescale 1ns/1ps
module tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        irq;
   logic        sample_valid;
   logic [1:0]  sample_soc;
   logic [11:0] sample_data;
   logic [1:0]  upper_limit_trip;
   logic [1:0]  lower_limit_trip;
   logic [1:0]  zero_cross;
   int          n_fail, total_checks, cyc;
   int          got_ev[4], exp_ev[4], mf[4], ml[4], cont[4], ut[2], lt[2], zc[2];
   adc_evt_if adc_evt_if_i ();
   adc_evt_dev adc_evt_dev_i (.link(adc_evt_if_i), .pclk, .presetn, .sample_valid, .sample_soc,
      .sample_data, .upper_limit_trip, .lower_limit_trip, .zero_cross);
   adc_evt_host adc_evt_host_i (.link(adc_evt_if_i), .pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr(), .irq);
   adc_evt_properties adc_evt_properties_i (.pclk, .presetn,
      .req(adc_evt_if_i.req), .wr(adc_evt_if_i.wr), .addr(adc_evt_if_i.addr),
      .wdata(adc_evt_if_i.wdata), .rdata(adc_evt_if_i.rdata), .ack(adc_evt_if_i.ack),
      .conv_event(adc_evt_if_i.conv_event));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge pclk) begin
      cyc++;
      for (int l = 0; l < 4; l++) got_ev[l] += (adc_evt_if_i.conv_event[l] === 1'b1);
      for (int u = 0; u < 2; u++) begin
         ut[u] += (upper_limit_trip[u] === 1'b1);
         lt[u] += (lower_limit_trip[u] === 1'b1);
         zc[u] += (zero_cross[u] === 1'b1);
      end
      if (cyc > 40000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cmd(input logic w, input logic [4:0] i, input logic [15:0] d,
                      output logic [15:0] q);
      logic [31:0] r;
      apb(1'b1, adc_evt_pkg::H_CMD, {7'h00, w, 3'h0, i, d}, r);
      do apb(1'b0, adc_evt_pkg::H_STAT, 32'h0, r); while (r[adc_evt_pkg::HS_CMD] !== 1'b1);
      apb(1'b0, adc_evt_pkg::H_RDATA, 32'h0, r);
      q = r[15:0];
   endtask : cmd
   task automatic smp(input logic [1:0] s, input logic [11:0] v, input int gap);
      @(posedge pclk);
      {sample_valid, sample_soc, sample_data} <= {1'b1, s, v};
      @(posedge pclk);
      sample_valid <= 1'b0;
      repeat (gap) @(posedge pclk);
      if (mf[s] != 0) ml[s] = 1;
      if (mf[s] == 0 || cont[s] != 0) exp_ev[s]++;
      mf[s] = 1;
   endtask : smp
   task automatic cmp_model();
      logic [15:0] d, ef, el;
      {ef, el} = '0;
      for (int l = 0; l < 4; l++) begin
         ef[l] = (mf[l] != 0);
         el[l] = (ml[l] != 0);
         chk(got_ev[l], exp_ev[l]);
      end
      cmd(1'b0, adc_evt_pkg::A_FLAG, 16'h0, d);
      chk(d, ef);
      cmd(1'b0, adc_evt_pkg::A_LOST, 16'h0, d);
      chk(d, el);
   endtask : cmp_model
   initial begin
      logic [31:0] r;
      logic [15:0] d;
      logic [11:0] v;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {sample_valid, sample_soc, sample_data} = '0;
      void'($urandom(53691));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      cmd(1'b0, adc_evt_pkg::A_PP_BASE + 5'h02, 16'h0, d);
      chk(d, adc_evt_pkg::HI_RST);
      cmd(1'b1, adc_evt_pkg::A_SEL12, 16'h0100, d);
      cmd(1'b1, adc_evt_pkg::A_SEL34, 16'h0302, d);
      for (int l = 0; l < 4; l++) begin
         v = 12'($urandom);
         smp(2'(l), v, 8);
         smp(2'(l), ~v, 8);
      end
      cmd(1'b0, adc_evt_pkg::A_RESULT, 16'h0, d);
      chk(d, {4'h0, ~v});
      cmp_model();
      cmd(1'b1, adc_evt_pkg::A_LOST_CLR, 16'h0005, d);
      ml[0] = 0;
      ml[2] = 0;
      cmp_model();
      cmd(1'b1, adc_evt_pkg::A_FLAG_CLR, 16'h000f, d);
      cmd(1'b1, adc_evt_pkg::A_LOST_CLR, 16'h000a, d);
      mf = '{0, 0, 0, 0};
      ml = '{0, 0, 0, 0};
      cmd(1'b1, adc_evt_pkg::A_SEL12, 16'h0104, d);
      cont[0] = 1;
      repeat (3) smp(2'h0, 12'($urandom), 8);
      cmp_model();
      cmd(1'b1, adc_evt_pkg::A_PP_BASE + 5'h02, 16'h0800, d);
      cmd(1'b1, adc_evt_pkg::A_PP_BASE + 5'h03, 16'h0100, d);
      cmd(1'b1, adc_evt_pkg::A_PP_BASE + 5'h05, 16'h0800, d);
      for (int k = 0; k < 6; k++) begin
         v = k[0] ? 12'($urandom_range(255, 1)) : 12'($urandom_range(4095, 2304));
         smp(2'h0, v, 8);
         cmd(1'b0, adc_evt_pkg::A_PP_RES, 16'h0, d);
         chk(d, {4'h0, v});
         cmd(1'b0, adc_evt_pkg::A_PP_RES + 5'h01, 16'h0, d);
         chk(d, 16'({4'h0, v} - 16'h0800));
      end
      chk(ut[0] * 16 + lt[0], 32'h33);
      chk(ut[1] + lt[1] + zc[0], 0);
      chk(zc[1] >= 3, 1);
      cmp_model();
      cmd(1'b1, adc_evt_pkg::A_SEL12, 16'h0100, d);
      cmd(1'b1, adc_evt_pkg::A_FLAG_CLR, 16'h0001, d);
      cmd(1'b1, adc_evt_pkg::A_CTRL, 16'h0034, d);
      apb(1'b0, adc_evt_pkg::H_STAT, 32'h0, r);
      apb(1'b1, adc_evt_pkg::H_MASK, 32'h1, r);
      apb(1'b1, adc_evt_pkg::H_CTRL, 32'h3, r);
      v = 12'($urandom);
      smp(2'h0, v, 5);
      for (int n = 0; n < 300 && irq !== 1'b1; n++) @(negedge pclk);
      chk(irq, 1'b1);
      apb(1'b0, adc_evt_pkg::H_LAST, 32'h0, r);
      chk(r, {16'h0000, 4'h0, v});
      apb(1'b0, adc_evt_pkg::H_STAT, 32'h0, r);
      chk(r[0], 1'b1);
      apb(1'b1, adc_evt_pkg::H_MASK, 32'h0, r);
      @(negedge pclk);
      chk(irq, 1'b0);
      smp(2'h0, v, 5);
      smp(2'h0, ~v, 5);
      repeat (200) @(posedge pclk);
      @(negedge pclk);
      chk(irq, 1'b0);
      apb(1'b1, adc_evt_pkg::H_CTRL, 32'h0, r);
      cmd(1'b0, adc_evt_pkg::A_FLAG, 16'h0, d);
      chk(d, 16'h0000);
      apb(1'b0, 8'h40, 32'h0, r);
      chk(r, 32'h0);
      cmd(1'b0, 5'h1f, 16'h0, d);
      chk(d, 16'h0000);
      tally_and_finish();
   end
endmodule : tb

// File: src/adc_evt_dev.sv
// converter event flags, lost flags, late event timing and postproc units
// Functional notes
// R1: without keep-firing, set flag blocks further events
// R2: with keep-firing, every event fires regardless
// R3: event in clear cycle leaves flag set
// R4: event on already set flag sets lost
// R5: writing one to lost clear clears it
// R6: servicer rereads lost, clears flag again
// R7: servicer clears flag before next event
// R8: postproc subtracts offset, detects zero crossing
// R9: limit compares wrong on signed postproc result
// R10: two postproc units may share one slot
// R11: late event may precede result latching
// R12: lead of three cycles only divider above 2, 12-bit
// R13: event feeds coprocessor, interrupt, polling or dma
// R14: dma user does dummy transfer before result
// R15: four lines, select bits two per register
`timescale 1ns/1ps
module adc_evt_dev (
   adc_evt_if.dev            link,
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         sample_valid,
   input  wire logic [1:0]   sample_soc,
   input  wire logic [11:0]  sample_data,
   output logic      [1:0]   upper_limit_trip,
   output logic      [1:0]   lower_limit_trip,
   output logic      [1:0]   zero_cross
);
   logic [3:0]  conversion_event_flag;
   logic [3:0]  event_lost_flag;
   logic [15:0] event_select_pair [2];
   logic [15:0] ctrl;
   logic [15:0] conversion_result;
   logic [15:0] pp_cfg [adc_evt_pkg::PPU];
   logic [15:0] pp_ofs [adc_evt_pkg::PPU];
   logic [15:0] pp_hi  [adc_evt_pkg::PPU];
   logic [15:0] pp_lo  [adc_evt_pkg::PPU];
   logic [15:0] postproc_result [adc_evt_pkg::PPU];
   logic [5:0]  pp_stat;
   logic        ack;
   logic [15:0] rdata;
   logic [3:0]  evt_out;
   logic        pend_busy;
   logic [3:0]  pend_cnt;
   logic [1:0]  pend_soc;
   logic [11:0] pend_data;
   logic        wr_hit;
   logic        rd_hit;
   logic        latch_now;
   logic        fire;
   logic [1:0]  fire_soc;
   logic [3:0]  ev;
   logic [3:0]  next_flag;
   logic [3:0]  next_lost;

   assign link.ack        = ack;
   assign link.rdata      = rdata;
   assign link.conv_event = evt_out;

   function automatic logic [1:0] line_soc(input logic [15:0] pair, input int half);
      line_soc = pair[half*adc_evt_pkg::SEL_HALF+adc_evt_pkg::SEL_SOC +: 2];
   endfunction : line_soc

   function automatic logic line_cont(input logic [15:0] pair, input int half);
      line_cont = pair[half*adc_evt_pkg::SEL_HALF+adc_evt_pkg::SEL_CONT];
   endfunction : line_cont

   // cycles from sample to result latching; only a slow divider in 12-bit leads by 3+
   function automatic logic [3:0] lat_delay(input logic [15:0] c);
      if (c[adc_evt_pkg::CTL_RES12] && c[adc_evt_pkg::CTL_DIV +: 4] > adc_evt_pkg::DIV_LEAD)
         lat_delay = c[adc_evt_pkg::CTL_DIV +: 4]; // see R12
      else
         lat_delay = adc_evt_pkg::LAT_MIN;
   endfunction : lat_delay

   assign wr_hit = link.req & link.wr & ~ack;
   assign rd_hit = link.req & ~link.wr & ~ack;

   // register link answers one cycle after a fresh request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack <= 1'b0;
      end else begin
         ack <= link.req & ~ack;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= 16'h0000;
      end else if (rd_hit) begin
         case (link.addr)
            adc_evt_pkg::A_FLAG:    rdata <= {12'h000, conversion_event_flag};
            adc_evt_pkg::A_LOST:    rdata <= {12'h000, event_lost_flag};
            adc_evt_pkg::A_SEL12:   rdata <= event_select_pair[0];
            adc_evt_pkg::A_SEL34:   rdata <= event_select_pair[1];
            adc_evt_pkg::A_RESULT:  rdata <= conversion_result;
            adc_evt_pkg::A_CTRL:    rdata <= ctrl;
            adc_evt_pkg::A_PP_STAT: rdata <= {10'h000, pp_stat};
            default: begin
               if (link.addr[4:3] == adc_evt_pkg::A_PP_BASE[4:3]) begin
                  case (link.addr[1:0])
                     adc_evt_pkg::PP_CFG: rdata <= pp_cfg[link.addr[2]];
                     adc_evt_pkg::PP_OFS: rdata <= pp_ofs[link.addr[2]];
                     adc_evt_pkg::PP_HI:  rdata <= pp_hi[link.addr[2]];
                     default:             rdata <= pp_lo[link.addr[2]];
                  endcase
               end else if (link.addr[4:1] == adc_evt_pkg::A_PP_RES[4:1]) begin
                  rdata <= postproc_result[link.addr[0]];
               end else begin
                  rdata <= 16'h0000;
               end
            end
         endcase
      end
   end

   // configuration writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_select_pair[0] <= 16'h0000;
         event_select_pair[1] <= 16'h0000;
         ctrl <= adc_evt_pkg::CTRL_RST;
         for (int k = 0; k < adc_evt_pkg::PPU; k++) begin
            pp_cfg[k] <= 16'h0000;
            pp_ofs[k] <= 16'h0000;
            pp_hi[k]  <= adc_evt_pkg::HI_RST;
            pp_lo[k]  <= 16'h0000;
         end
      end else if (wr_hit) begin
         if (link.addr == adc_evt_pkg::A_SEL12) begin
            event_select_pair[0] <= link.wdata; // see R15
         end
         if (link.addr == adc_evt_pkg::A_SEL34) begin
            event_select_pair[1] <= link.wdata;
         end
         if (link.addr == adc_evt_pkg::A_CTRL) begin
            ctrl <= link.wdata;
         end
         if (link.addr[4:3] == adc_evt_pkg::A_PP_BASE[4:3]) begin
            case (link.addr[1:0])
               adc_evt_pkg::PP_CFG: pp_cfg[link.addr[2]] <= link.wdata;
               adc_evt_pkg::PP_OFS: pp_ofs[link.addr[2]] <= link.wdata;
               adc_evt_pkg::PP_HI:  pp_hi[link.addr[2]]  <= link.wdata;
               default:             pp_lo[link.addr[2]]  <= link.wdata;
            endcase
         end
      end
   end

   // conversion in flight until its result latches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_busy <= 1'b0;
         pend_cnt  <= 4'h0;
         pend_soc  <= 2'h0;
         pend_data <= 12'h000;
      end else if (sample_valid) begin
         pend_busy <= 1'b1;
         pend_cnt  <= lat_delay(ctrl);
         pend_soc  <= sample_soc;
         pend_data <= sample_data;
      end else if (pend_busy) begin
         pend_cnt  <= pend_cnt - 4'h1;
         pend_busy <= (pend_cnt != 4'h1);
      end
   end

   assign latch_now = pend_busy & (pend_cnt == 4'h1) & ~sample_valid;

   // late mode fires on sample arrival, ahead of the latch
   always_comb begin
      if (ctrl[adc_evt_pkg::CTL_LATE]) begin
         fire     = sample_valid; // see R11
         fire_soc = sample_soc;
      end else begin
         fire     = latch_now;
         fire_soc = pend_soc;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_result <= 16'h0000;
      end else if (latch_now) begin
         conversion_result <= {4'h0, pend_data};
      end
   end

   always_comb begin
      for (int i = 0; i < adc_evt_pkg::LINES; i++) begin
         ev[i] = fire & (line_soc(event_select_pair[i/2], i%2) == fire_soc);
         next_flag[i] = conversion_event_flag[i];
         next_lost[i] = event_lost_flag[i];
         if (wr_hit && link.addr == adc_evt_pkg::A_FLAG_CLR && link.wdata[i]) begin
            next_flag[i] = 1'b0;
         end
         if (wr_hit && link.addr == adc_evt_pkg::A_LOST_CLR && link.wdata[i]) begin
            next_lost[i] = 1'b0; // see R5
         end
         if (ev[i]) begin
            next_flag[i] = 1'b1; // see R3
         end
         if (ev[i] && conversion_event_flag[i]) begin
            next_lost[i] = 1'b1; // see R4
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_event_flag <= 4'h0;
         event_lost_flag       <= 4'h0;
      end else begin
         conversion_event_flag <= next_flag;
         event_lost_flag       <= next_lost;
      end
   end

   // event pulse to coprocessor, cpu interrupt or dma trigger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_out <= 4'h0;
      end else begin
         for (int i = 0; i < adc_evt_pkg::LINES; i++) begin
            evt_out[i] <= ev[i] & (line_cont(event_select_pair[i/2], i%2) // see R2
                          | ~conversion_event_flag[i]); // see R1 R13
         end
      end
   end

   // each unit picks its own slot, so both may watch the same one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < adc_evt_pkg::PPU; k++) begin
            postproc_result[k] <= 16'h0000;
         end
         upper_limit_trip <= 2'b00;
         lower_limit_trip <= 2'b00;
         zero_cross       <= 2'b00;
         pp_stat          <= 6'h00;
      end else begin
         for (int k = 0; k < adc_evt_pkg::PPU; k++) begin
            upper_limit_trip[k] <= 1'b0;
            lower_limit_trip[k] <= 1'b0;
            zero_cross[k]       <= 1'b0;
            if (latch_now && pp_cfg[k][1:0] == pend_soc) begin // see R10
               postproc_result[k] <= {4'h0, pend_data} - pp_ofs[k]; // see R8
               // compares treat the result as unsigned, wrong once it goes negative
               upper_limit_trip[k] <= ({4'h0, pend_data} - pp_ofs[k]) > pp_hi[k]; // see R9
               lower_limit_trip[k] <= ({4'h0, pend_data} - pp_ofs[k]) < pp_lo[k];
               zero_cross[k] <= postproc_result[k][15] ^ (pp_ofs[k] > {4'h0, pend_data});
               pp_stat[k]   <= ({4'h0, pend_data} - pp_ofs[k]) > pp_hi[k];
               pp_stat[k+2] <= ({4'h0, pend_data} - pp_ofs[k]) < pp_lo[k];
               pp_stat[k+4] <= postproc_result[k][15] ^ (pp_ofs[k] > {4'h0, pend_data});
            end
         end
      end
   end
endmodule : adc_evt_dev

// File: src/adc_evt_host.sv
// servicing end: apb controlled engine that acknowledges converter events
`timescale 1ns/1ps
module adc_evt_host (
   adc_evt_if.host           link,
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   output logic              irq
);
   typedef enum {S_IDLE, S_DUMMY, S_RES, S_CLR, S_LOST, S_CLR2, S_OCLR, S_CMD} st_e;
   st_e         st;
   logic [2:0]  ctrl;
   logic [2:0]  stat;
   logic [2:0]  mask;
   logic [24:0] cmd;
   logic        cmd_go;
   logic [15:0] rd_last;
   logic [17:0] last;
   logic [3:0]  pend;
   logic [3:0]  done;
   logic [1:0]  line;
   logic [2:0]  ev_set;
   logic        req;
   logic        wr;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic        acc;

   assign link.req   = req;
   assign link.wr    = wr;
   assign link.addr  = addr;
   assign link.wdata = wdata;
   assign acc = psel & penable & pready;

   // zero wait apb slave: ready and data prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         ctrl    <= 3'h0;
         mask    <= 3'h0;
         cmd     <= 25'h0000000;
         cmd_go  <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         if (psel && !penable) begin
            case (paddr)
               adc_evt_pkg::H_CTRL:  prdata <= {29'h0, ctrl};
               adc_evt_pkg::H_STAT:  prdata <= {29'h0, stat};
               adc_evt_pkg::H_MASK:  prdata <= {29'h0, mask};
               adc_evt_pkg::H_CMD:   prdata <= {7'h00, cmd};
               adc_evt_pkg::H_RDATA: prdata <= {16'h0000, rd_last};
               adc_evt_pkg::H_LAST:  prdata <= {14'h0000, last};
               default:              prdata <= 32'h00000000;
            endcase
         end
         if (st == S_CMD && link.ack) begin
            cmd_go <= 1'b0;
         end
         if (acc && pwrite) begin
            case (paddr)
               adc_evt_pkg::H_CTRL: ctrl <= pwdata[2:0];
               adc_evt_pkg::H_MASK: mask <= pwdata[2:0];
               adc_evt_pkg::H_CMD: begin
                  cmd    <= pwdata[24:0];
                  cmd_go <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   // sticky status, cleared by a read; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat <= 3'h0;
         irq  <= 1'b0;
      end else begin
         if (acc && !pwrite && paddr == adc_evt_pkg::H_STAT) begin
            stat <= (stat & ~prdata[2:0]) | ev_set;
         end else begin
            stat <= stat | ev_set;
         end
         irq <= |((stat | ev_set) & mask);
      end
   end

   always_comb begin
      ev_set = 3'h0;
      ev_set[adc_evt_pkg::HS_SERV] = ((st == S_LOST) & link.ack & ~link.rdata[line])
                                     | ((st == S_CLR2) & link.ack);
      ev_set[adc_evt_pkg::HS_LOST] = (st == S_LOST) & link.ack & link.rdata[line];
      ev_set[adc_evt_pkg::HS_CMD]  = (st == S_CMD) & link.ack;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= 4'h0;
      end else begin
         pend <= (pend & ~done) | (link.conv_event & {4{ctrl[adc_evt_pkg::HC_SVC]}});
      end
   end

   always_comb begin
      done = 4'h0;
      if (st == S_CLR && link.ack) begin
         done[line] = 1'b1;
      end
   end

   // one link access per state; the next request follows the answer at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st      <= S_IDLE;
         req     <= 1'b0;
         wr      <= 1'b0;
         addr    <= 5'h00;
         wdata   <= 16'h0000;
         line    <= 2'h0;
         rd_last <= 16'h0000;
         last    <= 18'h00000;
      end else begin
         case (st)
            S_IDLE: begin
               if (cmd_go) begin
                  st    <= S_CMD;
                  req   <= 1'b1;
                  wr    <= cmd[adc_evt_pkg::CMD_WR];
                  addr  <= cmd[adc_evt_pkg::CMD_ADDR +: 5];
                  wdata <= cmd[15:0];
               end else if (ctrl[adc_evt_pkg::HC_SVC] && pend != 4'h0) begin
                  // service at once so the flag clears before the next event; see R7
                  line <= pend[0] ? 2'd0 : pend[1] ? 2'd1 : pend[2] ? 2'd2 : 2'd3;
                  req  <= 1'b1;
                  wr   <= 1'b0;
                  addr <= ctrl[adc_evt_pkg::HC_DUAL] ? adc_evt_pkg::A_FLAG
                                                      : adc_evt_pkg::A_RESULT;
                  st   <= ctrl[adc_evt_pkg::HC_DUAL] ? S_DUMMY : S_RES; // see R14
               end
            end
            S_DUMMY: if (link.ack) begin
               st   <= S_RES;
               addr <= adc_evt_pkg::A_RESULT;
            end
            S_RES: if (link.ack) begin
               last  <= {line, link.rdata};
               st    <= S_CLR;
               wr    <= 1'b1;
               addr  <= adc_evt_pkg::A_FLAG_CLR;
               wdata <= 16'h0001 << line;
            end
            S_CLR: if (link.ack) begin
               st   <= S_LOST;
               wr   <= 1'b0;
               addr <= adc_evt_pkg::A_LOST; // see R6
            end
            S_LOST: if (link.ack) begin
               if (link.rdata[line]) begin
                  st   <= S_CLR2;
                  wr   <= 1'b1;
                  addr <= adc_evt_pkg::A_FLAG_CLR;
               end else begin
                  st  <= S_IDLE;
                  req <= 1'b0;
               end
            end
            S_CLR2: if (link.ack) begin
               if (ctrl[adc_evt_pkg::HC_OCLR]) begin
                  st   <= S_OCLR;
                  addr <= adc_evt_pkg::A_LOST_CLR;
               end else begin
                  st  <= S_IDLE;
                  req <= 1'b0;
               end
            end
            S_OCLR: if (link.ack) begin
               st  <= S_IDLE;
               req <= 1'b0;
            end
            S_CMD: if (link.ack) begin
               rd_last <= link.rdata;
               st      <= S_IDLE;
               req     <= 1'b0;
            end
            default: st <= S_IDLE;
         endcase
      end
   end
endmodule : adc_evt_host
